//--- eds_pkg.sv
// Package of descriptor layout constants for the descriptor source link
package eds_pkg;
  // Descriptor type codes
  localparam logic [7:0] TYPE_STRING = 8'h03;
  localparam logic [7:0] TYPE_EP_COMP = 8'h30;
  localparam logic [7:0] TYPE_ISO_EXT = 8'h31;
  // Lengths
  localparam logic [7:0] LEN_EP_COMP = 8'h06;
  localparam logic [7:0] LEN_ISO_EXT = 8'h08;
  localparam logic [7:0] LEN_HDR = 8'h02;
  // Field positions
  localparam int OFS_BUDGET = 4;
  localparam int BIT_EXT_FLAG = 7;
  // Budget when the extended companion carries the real count
  localparam logic [15:0] BUDGET_EXT = 16'h0001;
  // Threshold above which the extended companion is needed (48K bytes)
  localparam logic [31:0] EXT_THRESHOLD = 32'h0000C000;
  // Endpoint types
  localparam logic [1:0] EP_CTRL = 2'h0;
  localparam logic [1:0] EP_ISO = 2'h1;
  localparam logic [1:0] EP_BULK = 2'h2;
  localparam logic [1:0] EP_INT = 2'h3;
  // Request kinds
  typedef enum logic [1:0] {
    EDS_REQ_CONFIG,
    EDS_REQ_STRING,
    EDS_REQ_DIRECT_EXT
  } eds_req_t;
endpackage

//--- eds_link_if.sv
// Interface joining the descriptor host end and the device end
`timescale 1ns/10ps
interface eds_link_if;
  logic req_valid;
  eds_pkg::eds_req_t req_kind;
  logic [7:0] req_index;
  logic [15:0] req_langid;
  logic busy;
  logic byte_valid;
  logic [7:0] byte_data;
  logic byte_last;
  logic stall;
  modport dev (input req_valid, req_kind, req_index, req_langid,
    output busy, byte_valid, byte_data, byte_last, stall);
  modport host (output req_valid, req_kind, req_index, req_langid,
    input busy, byte_valid, byte_data, byte_last, stall);
endinterface

//--- eds_host.sv
// Host end: issues descriptor requests and collects returned bytes
`timescale 1ns/10ps
module eds_host (
  input wire logic mclk,
  input wire logic rst_n,
  eds_link_if.host link,
  input wire logic cmd_valid,
  input wire eds_pkg::eds_req_t cmd_kind,
  input wire logic [7:0] cmd_index,
  input wire logic [15:0] cmd_langid,
  output logic cmd_ready,
  output logic [7:0] rx_len,
  output logic [7:0] rx_count,
  output logic [15:0] rx_word,
  output logic rx_done,
  output logic rx_stall
);
  import eds_pkg::*;

  logic [7:0] next_rx_len;
  logic [7:0] next_rx_count;
  logic [15:0] next_rx_word;
  logic next_rx_done;
  logic next_rx_stall;
  logic waiting;
  logic next_waiting;

  // Request goes straight out; language id named by caller
  assign link.req_valid = cmd_valid && !waiting && !link.busy;
  assign link.req_kind = cmd_kind;
  assign link.req_index = cmd_index;
  assign link.req_langid = cmd_langid;
  assign cmd_ready = !waiting && !link.busy;

  // Collect bytes; first byte is length, collection runs until the byte marked last
  always_comb begin
    next_waiting = waiting;
    next_rx_len = rx_len;
    next_rx_count = rx_count;
    next_rx_word = rx_word;
    next_rx_done = 1'b0;
    next_rx_stall = rx_stall;
    if (link.req_valid) begin
      next_waiting = 1'b1;
      next_rx_count = 8'h00;
      next_rx_stall = 1'b0;
    end
    if (waiting && link.stall) begin
      next_waiting = 1'b0;
      next_rx_stall = 1'b1;
      next_rx_done = 1'b1;
    end else if (waiting && link.byte_valid) begin
      if (rx_count == 8'h00) begin
        next_rx_len = link.byte_data;
      end
      // Little-endian pairs: low byte first
      next_rx_word = {link.byte_data, rx_word[15:8]};
      next_rx_count = rx_count + 8'h01;
      if (link.byte_last) begin
        next_waiting = 1'b0;
        next_rx_done = 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      waiting <= 1'b0;
      rx_len <= 8'h00;
      rx_count <= 8'h00;
      rx_word <= 16'h0000;
      rx_done <= 1'b0;
      rx_stall <= 1'b0;
    end else begin
      waiting <= next_waiting;
      rx_len <= next_rx_len;
      rx_count <= next_rx_count;
      rx_word <= next_rx_word;
      rx_done <= next_rx_done;
      rx_stall <= next_rx_stall;
    end
  end
endmodule

//--- eds_device.sv
// Device end: serves endpoint companion and string descriptor bytes
`timescale 1ns/10ps
module eds_device #(
  parameter int STR_UNITS = 4,
  parameter int NUM_LANG = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  eds_link_if.dev link,
  input wire logic link_above_gen1,
  input wire logic strings_present,
  input wire logic [1:0] ep_type,
  input wire logic [7:0] ep_max_burst,
  input wire logic [1:0] ep_mult,
  input wire logic [31:0] ep_bytes_per_si,
  input wire logic [NUM_LANG*16-1:0] lang_ids,
  input wire logic [STR_UNITS*16-1:0] str_units,
  input wire logic [7:0] str_index_in,
  output logic [7:0] str_index_out,
  output logic ext_active,
  output logic [31:0] active_bytes_per_si
);
  import eds_pkg::*;

  typedef enum logic [1:0] {EDS_IDLE, EDS_COMP, EDS_EXT, EDS_STR} eds_st_t;

  localparam int LANG_BYTES = NUM_LANG * 2;
  localparam int STR_BYTES = STR_UNITS * 2;

  eds_st_t st;
  eds_st_t next_st;
  logic [7:0] pos;
  logic [7:0] next_pos;
  logic lang_mode;
  logic next_lang_mode;
  logic [7:0] data;
  logic [7:0] next_data;
  logic valid;
  logic next_valid;
  logic last;
  logic next_last;
  logic stall;
  logic next_stall;
  logic [7:0] attr;
  logic [15:0] budget;
  logic need_ext;
  logic [7:0] str_len;

  // Pick byte n of a little-endian word
  function automatic logic [7:0] le_byte(input logic [31:0] w,
                                         input logic [1:0] n);
    le_byte = w[8*n +: 8];
  endfunction

  // Extended companion only at the faster rate and above the threshold
  assign need_ext = (ep_type == EP_ISO) && link_above_gen1 &&
    (ep_bytes_per_si > EXT_THRESHOLD);
  assign attr = (ep_type == EP_ISO) ?
    {need_ext, 5'h00, need_ext ? 2'h0 : ep_mult} : 8'h00;

  // Budget field per endpoint type
  always_comb begin
    if (ep_type == EP_CTRL || ep_type == EP_BULK) begin
      budget = 16'h0000;
    end else if (need_ext) begin
      budget = BUDGET_EXT;
    end else begin
      budget = ep_bytes_per_si[15:0];
    end
  end

  // String indexes forced to zero when strings are absent
  assign str_index_out = strings_present ? str_index_in : 8'h00;
  assign str_len = lang_mode ? 8'(LANG_BYTES + 2) : 8'(STR_BYTES + 2);

  // Endpoint runs on the extended count whenever that descriptor exists
  assign ext_active = need_ext;
  assign active_bytes_per_si = need_ext ? ep_bytes_per_si :
    {16'h0000, budget};

  assign link.busy = (st != EDS_IDLE);
  assign link.byte_valid = valid;
  assign link.byte_data = data;
  assign link.byte_last = last;
  assign link.stall = stall;

  // Byte sequencer: one byte per clock, length byte always first
  always_comb begin
    next_st = st;
    next_pos = pos;
    next_lang_mode = lang_mode;
    next_data = 8'h00;
    next_valid = 1'b0;
    next_last = 1'b0;
    next_stall = 1'b0;
    unique case (st)
      EDS_IDLE: begin
        if (link.req_valid) begin
          next_pos = 8'h00;
          unique case (link.req_kind)
            EDS_REQ_CONFIG: next_st = EDS_COMP;
            EDS_REQ_STRING: begin
              if (strings_present) begin
                next_st = EDS_STR;
              end else begin
                next_stall = 1'b1;
              end
            end
            EDS_REQ_DIRECT_EXT: next_stall = 1'b1;
            default: next_stall = 1'b1;
          endcase
          next_lang_mode = (link.req_index == 8'h00);
        end
      end
      EDS_COMP: begin
        next_valid = 1'b1;
        unique case (pos)
          8'h00: next_data = LEN_EP_COMP;
          8'h01: next_data = TYPE_EP_COMP;
          8'h02: next_data = ep_max_burst;
          8'h03: next_data = attr;
          8'h04: next_data = le_byte({16'h0000, budget}, 2'h0);
          default: next_data = le_byte({16'h0000, budget}, 2'h1);
        endcase
        next_pos = pos + 8'h01;
        if (pos == 8'(LEN_EP_COMP - 8'h01)) begin
          next_pos = 8'h00;
          if (need_ext) begin
            next_st = EDS_EXT;
          end else begin
            next_st = EDS_IDLE;
            next_last = 1'b1;
          end
        end
      end
      EDS_EXT: begin
        next_valid = 1'b1;
        if (pos == 8'h00) begin
          next_data = LEN_EXT_OR_ZERO(1'b1);
        end else if (pos == 8'h01) begin
          next_data = TYPE_ISO_EXT;
        end else if (pos < 8'(OFS_BUDGET)) begin
          next_data = 8'h00;
        end else begin
          next_data = le_byte(ep_bytes_per_si, 2'(pos - 8'(OFS_BUDGET)));
        end
        next_pos = pos + 8'h01;
        if (pos == 8'(LEN_ISO_EXT - 8'h01)) begin
          next_st = EDS_IDLE;
          next_last = 1'b1;
        end
      end
      EDS_STR: begin
        next_valid = 1'b1;
        if (pos == 8'h00) begin
          next_data = str_len;
        end else if (pos == 8'h01) begin
          next_data = TYPE_STRING;
        end else if (lang_mode) begin
          next_data = lang_ids[8*(pos-8'h02) +: 8];
        end else begin
          next_data = str_units[8*(pos-8'h02) +: 8];
        end
        next_pos = pos + 8'h01;
        if (pos == str_len - 8'h01) begin
          next_st = EDS_IDLE;
          next_last = 1'b1;
        end
      end
    endcase
  end

  // Length of the extended companion, kept in one place
  function automatic logic [7:0] LEN_EXT_OR_ZERO(input logic en);
    LEN_EXT_OR_ZERO = en ? LEN_ISO_EXT : 8'h00;
  endfunction

  // State registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= EDS_IDLE;
      pos <= 8'h00;
      lang_mode <= 1'b0;
      data <= 8'h00;
      valid <= 1'b0;
      last <= 1'b0;
      stall <= 1'b0;
    end else begin
      st <= next_st;
      pos <= next_pos;
      lang_mode <= next_lang_mode;
      data <= next_data;
      valid <= next_valid;
      last <= next_last;
      stall <= next_stall;
    end
  end
endmodule

//--- eds_link_chk.sv
// Checker of the request and byte stream link between both ends
`timescale 1ns/10ps
module eds_link_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire eds_pkg::eds_req_t req_kind,
  input wire logic busy,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic byte_last,
  input wire logic stall
);
  import eds_pkg::*;
  logic take;
  // A request counts only at an edge where the device is free
  assign take = req_valid && !busy;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // A refusal answers one edge after the take, a byte stream two edges after
  a_direct_refused: assert property (
    take && req_kind == EDS_REQ_DIRECT_EXT
    |=> stall && !byte_valid && !busy)
    else $error("direct request not refused");
  a_config_len: assert property (take && req_kind == EDS_REQ_CONFIG
    |-> ##2 byte_valid && byte_data == LEN_EP_COMP)
    else $error("config answer does not open with its length");
  a_string_even: assert property (
    take && req_kind == EDS_REQ_STRING
    |=> stall or ##1 (byte_valid && !byte_data[0] && byte_data >= LEN_HDR))
    else $error("string length byte not header plus whole units");
  a_stall_quiet: assert property (stall |-> !byte_valid ##1 !stall)
    else $error("refusal not a lone pulse without bytes");
  a_last_valid: assert property (byte_last |-> byte_valid)
    else $error("final marker without a byte");
  a_last_ends: assert property (byte_last |-> ##[1:3] !busy)
    else $error("device still busy after final byte");
  // Busy drops as the final byte goes out, so it stands for all but that one
  a_bytes_busy: assert property (byte_valid |-> busy != byte_last)
    else $error("byte outside a served request");
  // After a take the device is either serving or refusing, never both
  a_take_quiet: assert property (
    take |=> !byte_valid && (busy != stall))
    else $error("answer came before its length cycle");
endmodule

//--- tb_top.sv
// Testbench driving the host end against the device end
`timescale 1ns/10ps
module tb_top;
  import eds_pkg::*;
  logic mclk, rst_n, cmd_valid, above, strs, cmd_ready, rx_done, rx_stall;
  logic ext_active;
  eds_req_t cmd_kind;
  logic [7:0] cmd_index, burst, sidx, str_index_out, rx_len, rx_count;
  logic [15:0] rx_word, langid;
  logic [1:0] ep_type, mult;
  logic [31:0] bps, active_bytes_per_si;
  logic [7:0] got[$];
  logic [8:0] exp[$]; // Bit 8 marks a byte left unchecked
  int n_fail = 0;
  int cmp_count = 0;
  eds_link_if eds_link_if_inst();
  eds_host eds_host_inst (.mclk(mclk), .rst_n(rst_n),
    .link(eds_link_if_inst), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_index(cmd_index), .cmd_langid(langid), .cmd_ready(cmd_ready),
    .rx_len(rx_len), .rx_count(rx_count), .rx_word(rx_word),
    .rx_done(rx_done), .rx_stall(rx_stall));
  eds_device #(.STR_UNITS(2), .NUM_LANG(1)) eds_device_inst (.mclk(mclk),
    .rst_n(rst_n), .link(eds_link_if_inst), .link_above_gen1(above),
    .strings_present(strs), .ep_type(ep_type), .ep_max_burst(burst),
    .ep_mult(mult), .ep_bytes_per_si(bps), .lang_ids(16'h0409),
    .str_units(32'h00650041), .str_index_in(sidx),
    .str_index_out(str_index_out), .ext_active(ext_active),
    .active_bytes_per_si(active_bytes_per_si));
  eds_link_chk eds_link_chk_inst (.mclk(mclk), .rst_n(rst_n),
    .req_valid(eds_link_if_inst.req_valid),
    .req_kind(eds_link_if_inst.req_kind), .busy(eds_link_if_inst.busy),
    .byte_valid(eds_link_if_inst.byte_valid),
    .byte_data(eds_link_if_inst.byte_data),
    .byte_last(eds_link_if_inst.byte_last), .stall(eds_link_if_inst.stall));
  // --------------------------------------------------
  // Shared tasks
  // --------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, ex);
    cmp_count++;
    if (seen !== ex) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, ex, seen);
    end
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // One request, then the wire bytes and host view against exp
  task automatic run(input eds_req_t k, input logic [7:0] idx);
    got.delete();
    @(negedge mclk);
    for (int i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(negedge mclk);
    @(posedge mclk);
    cmd_kind <= k;
    cmd_index <= idx;
    cmd_valid <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    check("langid", eds_link_if_inst.req_langid, langid);
    for (int i = 0; i < 100 && rx_done !== 1'b1; i++) @(negedge mclk);
    check("byte count", got.size(), exp.size());
    foreach (exp[j]) begin
      if (!exp[j][8] && j < got.size()) begin
        check("byte", got[j], exp[j]);
      end
    end
    check("rx_count", rx_count, exp.size());
    if (exp.size() > 0) check("rx_len", rx_len, exp[0][7:0]);
    check("rx_stall", rx_stall, exp.size() == 0);
  endtask
  // Bytes are taken mid-cycle, clear of the launching edge
  always @(negedge mclk) begin
    if (eds_link_if_inst.byte_valid === 1'b1) begin
      got.push_back(eds_link_if_inst.byte_data);
    end
  end
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  // Hang guard, far above the hundred or so cycles the tests need
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    report_and_stop();
  end
  // --------------------------------------------------
  // Test sequence
  // --------------------------------------------------
  initial begin
    {rst_n, cmd_valid, cmd_index, above, strs} = {1'b0, 1'b0, 8'h00, 2'h3};
    cmd_kind = EDS_REQ_CONFIG;
    {ep_type, burst} = {EP_CTRL, 8'h03};
    mult = 2'h1;
    langid = 16'h0409;
    bps = 32'h0000C000;
    sidx = 8'h05;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    // Every endpoint type at exactly the 48K boundary: no extension
    for (int t = 0; t < 4; t++) begin
      @(posedge mclk);
      ep_type <= 2'(t);
      exp = '{9'h006, 9'h030, t == 0 ? 9'h100 : {1'b0, burst},
        t == 1 ? 9'h001 : 9'h000, 9'h000, t[0] ? 9'h0C0 : 9'h000};
      run(EDS_REQ_CONFIG, 8'h00);
      check("ext_active", ext_active, 1'b0);
      check("active bytes", active_bytes_per_si,
        t[0] ? 32'h0000C000 : 32'h00000000);
    end
    @(posedge mclk);
    ep_type <= EP_ISO;
    bps <= 32'h00012345;
    exp = '{9'h006, 9'h030, 9'h003, 9'h080, 9'h001, 9'h000, 9'h008,
      9'h031, 9'h000, 9'h000, 9'h045, 9'h023, 9'h001, 9'h000};
    run(EDS_REQ_CONFIG, 8'h00);
    check("ext_active", ext_active, 1'b1);
    check("active bytes", active_bytes_per_si, 32'h00012345);
    @(posedge mclk);
    above <= 1'b0;
    mult <= 2'h2;
    exp = '{9'h006, 9'h030, 9'h003, 9'h002, 9'h045, 9'h023};
    run(EDS_REQ_CONFIG, 8'h00);
    check("ext_active", ext_active, 1'b0);
    exp.delete();
    run(EDS_REQ_DIRECT_EXT, 8'h00);
    exp = '{9'h004, 9'h003, 9'h009, 9'h004};
    run(EDS_REQ_STRING, 8'h00);
    check("lang word", rx_word, 16'h0409);
    exp = '{9'h006, 9'h003, 9'h041, 9'h000, 9'h065, 9'h000};
    run(EDS_REQ_STRING, 8'h01);
    check("last unit", rx_word, 16'h0065);
    check("str index", str_index_out, 8'h05);
    @(posedge mclk);
    strs <= 1'b0;
    exp.delete();
    run(EDS_REQ_STRING, 8'h00);
    check("str index", str_index_out, 8'h00);
    report_and_stop();
  end
endmodule
